// File: hdl/dsr_pkg.sv
package dsr_pkg;
   // ************************************************************
   // Register offsets on the serial control bus.
   // ************************************************************
   localparam logic [7:0] ADDR_SELF_TEST_CONTROL = 8'h24;
   localparam logic [7:0] ADDR_SELF_TEST_ERROR_COUNT = 8'h25;
   localparam logic [7:0] ADDR_I2C_MASTER_CLOCK_HIGH_TIME = 8'h26;
   localparam logic [7:0] ADDR_I2C_MASTER_CLOCK_LOW_TIME = 8'h27;
   localparam logic [7:0] ADDR_AUDIO_PATH_CONTROL = 8'h28;

   // ************************************************************
   // Reset values.
   // ************************************************************
   localparam logic [7:0] RST_SELF_TEST_CONTROL = 8'h08;
   localparam logic [7:0] RST_SELF_TEST_ERROR_COUNT = 8'h00;
   localparam logic [7:0] RST_I2C_MASTER_CLOCK_HIGH_TIME = 8'h83;
   localparam logic [7:0] RST_I2C_MASTER_CLOCK_LOW_TIME = 8'h84;
   localparam logic [7:0] RST_AUDIO_PATH_CONTROL = 8'h00;

   // ************************************************************
   // Writable bit masks; the other bits are reserved and read zero.
   // ************************************************************
   localparam logic [7:0] MASK_SELF_TEST_CONTROL = 8'h0F;
   localparam logic [7:0] MASK_AUDIO_PATH_CONTROL = 8'h8D;

   // ************************************************************
   // Field positions.
   // ************************************************************
   localparam int BIT_ST_RUN = 0;          // Register copy of the self-test enable.
   localparam int BIT_ST_OSC_LO = 1;       // Oscillator select field, low bit.
   localparam int BIT_ST_OSC_HI = 2;       // Oscillator select field, high bit.
   localparam int BIT_ST_PIN_SOURCE = 3;   // Self-test enable taken from the pin.
   localparam int BIT_AP_SURROUND = 0;     // Surround transport enable.
   localparam int BIT_AP_AUDIO_OFF = 2;    // Audio serial outputs off; aux audio on the pins is not gated.
   localparam int BIT_AP_AUX_AUDIO = 3;    // Auxiliary audio on the general-purpose pins.
   localparam int BIT_AP_BLOCK_LOAD = 7;   // Block forward-channel loading.

   // ************************************************************
   // Oscillator select codes; both choose the nominal oscillator.
   // ************************************************************
   localparam logic [1:0] OSC_CODE_NOMINAL_A = 2'h0;
   localparam logic [1:0] OSC_CODE_NOMINAL_B = 2'h1;

   // ************************************************************
   // Timing.
   // ************************************************************
   localparam int CLK_PERIOD_PS = 5000;    // 200 MHz system clock.
   localparam int SCL_UNIT_PS = 50000;     // 50 ns per count of the clock timing registers.
   localparam logic [3:0] SCL_UNIT_CYC = 4'((SCL_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam logic [7:0] COUNT_ONE = 8'h01;
endpackage : dsr_pkg

// File: hdl/dsr_ctl_if.sv
`timescale 1ns/10ps
`default_nettype none
// Signals shared between the register bank and its two helpers.
interface dsr_ctl_if;
   logic [7:0] high_count;    // Master clock high time in 50 ns units.
   logic [7:0] low_count;     // Master clock low time and slave setup time.
   logic master_en;           // Local master is driving the clock.
   logic slave_data_strobe;   // Slave has just put data on the data line.
   logic scl_level_q;         // Clock level driven by the master.
   logic scl_hold_low_q;      // Slave keeps the clock low for setup.
   logic test_active;         // Self-test is running.
   logic error_strobe;        // One forward-channel error seen.
   logic power_down_n;        // Synchronised power-down, active low.
   logic [7:0] error_count_q; // Saturating error count.

   modport top (
      output high_count,
      output low_count,
      output master_en,
      output slave_data_strobe,
      input scl_level_q,
      input scl_hold_low_q,
      output test_active,
      output error_strobe,
      output power_down_n,
      input error_count_q
   );
   modport scl (
      input high_count,
      input low_count,
      input master_en,
      input slave_data_strobe,
      output scl_level_q,
      output scl_hold_low_q
   );
   modport cnt (
      input test_active,
      input error_strobe,
      input power_down_n,
      output error_count_q
   );
endinterface : dsr_ctl_if
`default_nettype wire

// File: hdl/dsr_scl_timer.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Clock timing for the local bus master and the slave setup time.
// ************************************************************
module dsr_scl_timer (
   input wire logic sys_clk,
   input wire logic resetn,
   dsr_ctl_if.scl ctl
);
   logic [3:0] m_pre_q;    // Master 50 ns prescaler.
   logic [3:0] m_pre_d;
   logic [7:0] m_units_q;  // Master units spent in the current phase.
   logic [7:0] m_units_d;
   logic [3:0] s_pre_q;    // Slave 50 ns prescaler.
   logic [3:0] s_pre_d;
   logic [7:0] s_units_q;  // Slave units spent holding the clock low.
   logic [7:0] s_units_d;
   logic scl_d;
   logic hold_d;

   // A zero count still gives one unit, so the clock never stops dead.
   wire [7:0] phase_len = ctl.scl_level_q ? ctl.high_count : ctl.low_count;
   wire [7:0] phase_min = (phase_len == dsr_pkg::COUNT_ZERO) ? dsr_pkg::COUNT_ONE : phase_len;
   wire m_tick = (m_pre_q == dsr_pkg::SCL_UNIT_CYC - 4'h1);
   wire m_phase_end = m_tick && (m_units_q == phase_min - dsr_pkg::COUNT_ONE);
   wire [7:0] setup_min = (ctl.low_count == dsr_pkg::COUNT_ZERO) ? dsr_pkg::COUNT_ONE : ctl.low_count;
   wire s_tick = (s_pre_q == dsr_pkg::SCL_UNIT_CYC - 4'h1);
   wire s_done = s_tick && (s_units_q == setup_min - dsr_pkg::COUNT_ONE);

   // Next-state logic for the master clock and the slave hold.
   always_comb begin
      m_pre_d = m_tick ? 4'h0 : m_pre_q + 4'h1;
      m_units_d = m_phase_end ? dsr_pkg::COUNT_ZERO : (m_tick ? m_units_q + dsr_pkg::COUNT_ONE : m_units_q);
      scl_d = m_phase_end ? !ctl.scl_level_q : ctl.scl_level_q;
      if (!ctl.master_en) begin
         // Idle master leaves the clock high, as an idle bus expects.
         m_pre_d = 4'h0;
         m_units_d = dsr_pkg::COUNT_ZERO;
         scl_d = 1'b1;
      end
      s_pre_d = s_tick ? 4'h0 : s_pre_q + 4'h1;
      s_units_d = s_tick ? s_units_q + dsr_pkg::COUNT_ONE : s_units_q;
      hold_d = ctl.scl_hold_low_q && !s_done;
      if (ctl.slave_data_strobe) begin
         // New data restarts the setup wait from its first unit.
         s_pre_d = 4'h0;
         s_units_d = dsr_pkg::COUNT_ZERO;
         hold_d = 1'b1;
      end else if (!ctl.scl_hold_low_q) begin
         s_pre_d = 4'h0;
         s_units_d = dsr_pkg::COUNT_ZERO;
      end
   end

   // State registers.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         m_pre_q <= 4'h0;
         m_units_q <= dsr_pkg::COUNT_ZERO;
         ctl.scl_level_q <= 1'b1;
         s_pre_q <= 4'h0;
         s_units_q <= dsr_pkg::COUNT_ZERO;
         ctl.scl_hold_low_q <= 1'b0;
      end else begin
         m_pre_q <= m_pre_d;
         m_units_q <= m_units_d;
         ctl.scl_level_q <= scl_d;
         s_pre_q <= s_pre_d;
         s_units_q <= s_units_d;
         ctl.scl_hold_low_q <= hold_d;
      end
   end
endmodule : dsr_scl_timer
`default_nettype wire

// File: hdl/dsr_err_counter.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Saturating forward-channel error counter for self-test.
// ************************************************************
module dsr_err_counter (
   input wire logic sys_clk,
   input wire logic resetn,
   dsr_ctl_if.cnt ctl
);
   logic active_q; // Self-test activity one cycle ago, for the start edge.

   wire run_start = ctl.test_active && !active_q;
   wire can_count = ctl.test_active && ctl.error_strobe && (ctl.error_count_q != dsr_pkg::COUNT_MAX);

   // Count errors only while the test runs; a new run or power-down clears.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         active_q <= 1'b0;
         ctl.error_count_q <= dsr_pkg::RST_SELF_TEST_ERROR_COUNT;
      end else begin
         active_q <= ctl.test_active;
         if (!ctl.power_down_n || run_start) begin
            ctl.error_count_q <= dsr_pkg::COUNT_ZERO;
         end else if (can_count) begin
            ctl.error_count_q <= ctl.error_count_q + dsr_pkg::COUNT_ONE;
         end
      end
   end
endmodule : dsr_err_counter
`default_nettype wire

// File: hdl/dsr_regs.sv
// Overview of operation
// - Control bit 3 picks pin or register enable
// - Oscillator field codes 00, 01 pick 33 MHz
// - Low frequency mode runs oscillator at 12.5 MHz
// - Error counter counts self-test errors, saturates 255
// - Counter clears on power-down and new run
// - Master clock high time in 50 ns units
// - Master clock low time in 50 ns units
// - Low time also sets slave data setup
// - Bit 7 blocks forward-channel loading of register
// - Bit 3 puts auxiliary audio on pins 1, 0
// - Bit 2 disables every audio serial output except aux audio on pins 1, 0
// - Bit 0 enables 5.1 or 7.1 audio, except in repeater mode with valid in-band data
// - Surround needs the data island transport
// - Low frequency indication follows the mode pin
`timescale 1ns/10ps
`default_nettype none
module dsr_regs (
   input wire logic sys_clk,
   input wire logic resetn,
   // Byte register port from the serial control bus decoder.
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   // Forward-channel load of the audio path register.
   input wire logic fwd_load,
   input wire logic [7:0] fwd_data,
   // Pins from outside the clock domain.
   input wire logic power_down_n_input,
   input wire logic self_test_pin,
   input wire logic low_frequency_select,
   input wire logic repeater_pin,
   // Same-domain status from the link logic.
   input wire logic fwd_error,
   input wire logic no_pixel_clock,
   input wire logic func_osc_cfg,
   input wire logic data_island_mode,
   input wire logic inband_valid,
   input wire logic inband_surround,
   // Local bus master and slave control.
   input wire logic master_en,
   input wire logic slave_data_strobe,
   output logic scl_out_q,
   output logic scl_oe_q,
   // Audio and general-purpose pins.
   input wire logic [3:0] audio_data,
   input wire logic audio_ws,
   input wire logic aux_ws,
   input wire logic aux_data,
   input wire logic [1:0] gpio_out,
   input wire logic [1:0] gpio_oe,
   output logic [3:0] audio_data_q,
   output logic audio_ws_q,
   output logic audio_oe_q,
   output logic [1:0] gpio_pin_q,
   output logic [1:0] gpio_pin_oe_q,
   output logic aux_audio_active_q,
   // Mode outputs.
   output logic self_test_active_q,
   output logic osc_enable_q,
   output logic osc_nominal_q,
   output logic osc_low_rate_q,
   output logic low_freq_status_q,
   output logic surround_active_q
);
   // ************************************************************
   // Pin synchronisers.
   // ************************************************************
   logic [3:0] sync1_q; // First stage, read only by the second.
   logic [3:0] sync2_q; // Second stage, safe for logic.

   // Two flip-flops on each asynchronous pin.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= {repeater_pin, low_frequency_select, self_test_pin, power_down_n_input};
         sync2_q <= sync1_q;
      end
   end

   wire pdn_s = sync2_q[0];        // Power-down, active low.
   wire test_pin_s = sync2_q[1];   // Self-test pin.
   wire low_freq_s = sync2_q[2];   // Low frequency mode pin.
   wire repeater_s = sync2_q[3];   // Repeater mode pin.

   // ************************************************************
   // Register storage.
   // ************************************************************
   logic [7:0] st_ctrl_q;
   logic [7:0] st_ctrl_d;
   logic [7:0] high_q;
   logic [7:0] high_d;
   logic [7:0] low_q;
   logic [7:0] low_d;
   logic [7:0] audio_ctrl_q;
   logic [7:0] audio_ctrl_d;

   wire wr_st = reg_wr && (reg_addr == dsr_pkg::ADDR_SELF_TEST_CONTROL);
   wire wr_high = reg_wr && (reg_addr == dsr_pkg::ADDR_I2C_MASTER_CLOCK_HIGH_TIME);
   wire wr_low = reg_wr && (reg_addr == dsr_pkg::ADDR_I2C_MASTER_CLOCK_LOW_TIME);
   wire wr_audio = reg_wr && (reg_addr == dsr_pkg::ADDR_AUDIO_PATH_CONTROL);
   // Forward loading is refused while the block bit is set; the host write wins a tie.
   wire load_ok = fwd_load && !audio_ctrl_q[dsr_pkg::BIT_AP_BLOCK_LOAD];

   // Next values; reserved bits are masked off on every path.
   always_comb begin
      st_ctrl_d = wr_st ? (reg_wdata & dsr_pkg::MASK_SELF_TEST_CONTROL) : st_ctrl_q;
      high_d = wr_high ? reg_wdata : high_q;
      low_d = wr_low ? reg_wdata : low_q;
      if (wr_audio) begin
         audio_ctrl_d = reg_wdata & dsr_pkg::MASK_AUDIO_PATH_CONTROL;
      end else if (load_ok) begin
         // The block bit itself is kept local so the far end cannot lock it.
         audio_ctrl_d = (fwd_data & dsr_pkg::MASK_AUDIO_PATH_CONTROL & ~8'h80)
            | (audio_ctrl_q & 8'h80);
      end else begin
         audio_ctrl_d = audio_ctrl_q;
      end
   end

   // Register flops.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st_ctrl_q <= dsr_pkg::RST_SELF_TEST_CONTROL;
         high_q <= dsr_pkg::RST_I2C_MASTER_CLOCK_HIGH_TIME;
         low_q <= dsr_pkg::RST_I2C_MASTER_CLOCK_LOW_TIME;
         audio_ctrl_q <= dsr_pkg::RST_AUDIO_PATH_CONTROL;
      end else begin
         st_ctrl_q <= st_ctrl_d;
         high_q <= high_d;
         low_q <= low_d;
         audio_ctrl_q <= audio_ctrl_d;
      end
   end

   // ************************************************************
   // Helpers: clock timing and the error counter.
   // ************************************************************
   dsr_ctl_if ctl ();

   // Self-test runs from the pin by default, or from the register copy.
   wire test_run = st_ctrl_q[dsr_pkg::BIT_ST_PIN_SOURCE] ? test_pin_s
      : st_ctrl_q[dsr_pkg::BIT_ST_RUN];

   assign ctl.high_count = high_q;
   assign ctl.low_count = low_q;
   assign ctl.master_en = master_en;
   assign ctl.slave_data_strobe = slave_data_strobe;
   assign ctl.test_active = test_run;
   assign ctl.error_strobe = fwd_error;
   assign ctl.power_down_n = pdn_s;

   dsr_scl_timer u_scl (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .ctl(ctl)
   );

   dsr_err_counter u_cnt (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .ctl(ctl)
   );

   // ************************************************************
   // Read path.
   // ************************************************************
   logic [7:0] rd_mux;

   // Unmapped addresses read zero; the error count is always readable, but
   // software should wait for the run to end before trusting it.
   always_comb begin
      unique case (reg_addr)
         dsr_pkg::ADDR_SELF_TEST_CONTROL: rd_mux = st_ctrl_q;
         dsr_pkg::ADDR_SELF_TEST_ERROR_COUNT: rd_mux = ctl.error_count_q;
         dsr_pkg::ADDR_I2C_MASTER_CLOCK_HIGH_TIME: rd_mux = high_q;
         dsr_pkg::ADDR_I2C_MASTER_CLOCK_LOW_TIME: rd_mux = low_q;
         dsr_pkg::ADDR_AUDIO_PATH_CONTROL: rd_mux = audio_ctrl_q;
         default: rd_mux = dsr_pkg::COUNT_ZERO;
      endcase
   end

   // Read data is captured on the strobe and held until the next read.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         reg_rdata_q <= dsr_pkg::COUNT_ZERO;
      end else if (reg_rd) begin
         reg_rdata_q <= rd_mux;
      end
   end

   // ************************************************************
   // Mode decode.
   // ************************************************************
   wire [1:0] osc_code = st_ctrl_q[dsr_pkg::BIT_ST_OSC_HI:dsr_pkg::BIT_ST_OSC_LO];
   wire osc_nominal = (osc_code == dsr_pkg::OSC_CODE_NOMINAL_A)
      || (osc_code == dsr_pkg::OSC_CODE_NOMINAL_B);
   // Oscillator is needed for self-test or for free-running without a pixel clock.
   wire osc_enable = test_run || (func_osc_cfg && no_pixel_clock);
   wire surround_req = (repeater_s && inband_valid) ? inband_surround
      : audio_ctrl_q[dsr_pkg::BIT_AP_SURROUND];
   wire surround = surround_req && data_island_mode;
   wire audio_off = audio_ctrl_q[dsr_pkg::BIT_AP_AUDIO_OFF];
   wire aux_on = audio_ctrl_q[dsr_pkg::BIT_AP_AUX_AUDIO];

   // All top-level outputs are registered so pins never see decode glitches.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         // The open-drain clock never drives high, in reset either.
         scl_out_q <= 1'b0;
         scl_oe_q <= 1'b0;
         audio_data_q <= 4'h0;
         audio_ws_q <= 1'b0;
         audio_oe_q <= 1'b0;
         gpio_pin_q <= 2'h0;
         gpio_pin_oe_q <= 2'h0;
         aux_audio_active_q <= 1'b0;
         self_test_active_q <= 1'b0;
         osc_enable_q <= 1'b0;
         osc_nominal_q <= 1'b1;
         osc_low_rate_q <= 1'b0;
         low_freq_status_q <= 1'b0;
         surround_active_q <= 1'b0;
      end else begin
         // Clock pin is open drain: drive low in the master low phase or slave hold.
         scl_out_q <= 1'b0;
         scl_oe_q <= (master_en && !ctl.scl_level_q) || ctl.scl_hold_low_q;
         audio_data_q <= audio_off ? 4'h0 : audio_data;
         audio_ws_q <= audio_off ? 1'b0 : audio_ws;
         audio_oe_q <= !audio_off;
         gpio_pin_q <= aux_on ? {aux_ws, aux_data} : gpio_out;
         gpio_pin_oe_q <= aux_on ? 2'h3 : gpio_oe;
         // Flags the pin mode, so it follows the routing bit alone.
         aux_audio_active_q <= aux_on;
         self_test_active_q <= test_run;
         osc_enable_q <= osc_enable;
         osc_nominal_q <= osc_nominal;
         osc_low_rate_q <= low_freq_s;
         low_freq_status_q <= low_freq_s;
         surround_active_q <= surround && !audio_off;
      end
   end
endmodule : dsr_regs
`default_nettype wire

// File: bench/dsr_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Port checker for the register bank.
// ****************************************
module dsr_chk (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_q,
   input wire logic master_en,
   input wire logic slave_data_strobe,
   input wire logic scl_out_q,
   input wire logic scl_oe_q,
   input wire logic aux_ws,
   input wire logic aux_data,
   input wire logic [1:0] gpio_out,
   input wire logic [1:0] gpio_oe,
   input wire logic [1:0] gpio_pin_q,
   input wire logic [1:0] gpio_pin_oe_q,
   input wire logic aux_audio_active_q,
   input wire logic [3:0] audio_data_q,
   input wire logic audio_ws_q,
   input wire logic audio_oe_q,
   input wire logic osc_low_rate_q,
   input wire logic low_freq_status_q,
   input wire logic surround_active_q,
   input wire logic data_island_mode
);
   // One clock domain, so clocking and reset are given once.
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h24 || reg_addr > 8'h28) |=> reg_rdata_q == 8'h00)
      else $error("unmapped read did not return zero");
   scl_open_drain_a: assert property (scl_out_q == 1'b0)
      else $error("clock output drove a high level");
   // The smallest setup count is one unit of ten cycles, so eight cycles of hold must always be seen.
   slave_setup_a: assert property (slave_data_strobe && !master_en |-> ##3 scl_oe_q [*8])
      else $error("slave setup hold too short");
   aux_pins_a: assert property (aux_audio_active_q |-> gpio_pin_oe_q == 2'h3 && gpio_pin_q == {$past(aux_ws), $past(aux_data)})
      else $error("aux audio not on the pins");
   gpio_normal_a: assert property ($past(resetn) && !aux_audio_active_q |-> gpio_pin_q == $past(gpio_out) && gpio_pin_oe_q == $past(gpio_oe))
      else $error("pins lost normal drive");
   audio_off_a: assert property (!audio_oe_q |-> audio_data_q == 4'h0 && !audio_ws_q)
      else $error("disabled audio output not quiet");
   surround_gate_a: assert property (surround_active_q |-> audio_oe_q)
      else $error("surround active with audio off");
   surround_island_a: assert property (surround_active_q |-> $past(data_island_mode))
      else $error("surround without data island transport");
   low_freq_a: assert property (osc_low_rate_q == low_freq_status_q)
      else $error("low frequency status and rate disagree");
endmodule : dsr_chk
`default_nettype wire

// File: bench/dsr_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Host model on the byte register port.
// ****************************************
module dsr_host (
   input wire logic sys_clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata_q
);
   // Strobes idle low from time zero.
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
   end
   // One write; data is inverted afterwards so stale data never looks valid.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   // One read; the answer stands until the next read, so it is taken a cycle late.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      #1;
      d = reg_rdata_q;
   endtask : rd
endmodule : dsr_host
`default_nettype wire

// File: bench/tb_deser_selftest_i2c_audio_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_deser_selftest_i2c_audio_regs;
   logic sys_clk, resetn, reg_wr, reg_rd, fwd_load, power_down_n_input, self_test_pin, low_frequency_select;
   logic repeater_pin, fwd_error, no_pixel_clock, func_osc_cfg, data_island_mode, inband_valid, inband_surround;
   logic master_en, slave_data_strobe, aux_ws, aux_data, audio_ws, scl_out_q, scl_oe_q, audio_ws_q, audio_oe_q;
   logic aux_audio_active_q, self_test_active_q, osc_enable_q, osc_nominal_q, osc_low_rate_q;
   logic low_freq_status_q, surround_active_q;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q, fwd_data, got;
   logic [3:0] audio_data, audio_data_q;
   logic [1:0] gpio_out, gpio_oe, gpio_pin_q, gpio_pin_oe_q;
   int failures, compares, n;
   // Rows hold address, written byte and the byte read back.
   localparam logic [23:0] ROWS [6] = '{24'h24F202, 24'h255A00, 24'h260101, 24'h27FEFE, 24'h287200, 24'h30AA00};
   localparam logic [7:0] DEF [5] = '{dsr_pkg::RST_SELF_TEST_CONTROL, dsr_pkg::RST_SELF_TEST_ERROR_COUNT,
      dsr_pkg::RST_I2C_MASTER_CLOCK_HIGH_TIME, dsr_pkg::RST_I2C_MASTER_CLOCK_LOW_TIME, dsr_pkg::RST_AUDIO_PATH_CONTROL};
   dsr_regs dut_u (.*);
   dsr_host host_u (.*);
   // ****************************************
   // Clock, checks and the closing task.
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic complete_run;
      if (failures == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic do_reset;
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask : do_reset
   // Counts whole cycles for which the clock pull-down holds the given level.
   task automatic phase(input logic lvl);
      n = 0;
      #1;
      while (scl_oe_q === lvl && n < 3000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask : phase
   // The whole run needs under six hundred cycles; ten thousand marks a hang.
   initial begin
      #50000;
      failures++;
      complete_run();
   end
   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin
      {resetn, fwd_load, fwd_error, no_pixel_clock, func_osc_cfg, inband_valid, inband_surround} = 7'h00;
      {master_en, slave_data_strobe, repeater_pin, low_frequency_select, self_test_pin} = 5'h00;
      {power_down_n_input, data_island_mode} = 2'h3;
      {aux_ws, aux_data, audio_ws, audio_data, gpio_out, gpio_oe, fwd_data} = {3'h5, 4'hA, 2'h2, 2'h1, 8'h00};
      failures = 0;
      compares = 0;
      do_reset();
      foreach (ROWS[i]) begin
         host_u.wr(ROWS[i][23:16], ROWS[i][15:8]);
         host_u.rd(ROWS[i][23:16], got);
         chk(got, ROWS[i][7:0]);
      end
      chk({7'h00, osc_nominal_q}, 8'h01);
      do_reset();
      for (int i = 0; i < 5; i++) begin
         host_u.rd(8'h24 + 8'(i), got);
         chk(got, DEF[i]);
      end
      // Master clock: three units low, two units high, ten cycles a unit.
      host_u.wr(8'h26, 8'h02);
      host_u.wr(8'h27, 8'h03);
      master_en <= 1'b1;
      phase(1'b0);
      phase(1'b1);
      chk(8'(n), 8'h1E);
      phase(1'b0);
      chk(8'(n), 8'h14);
      @(posedge sys_clk);
      master_en <= 1'b0;
      repeat (4) @(posedge sys_clk);
      slave_data_strobe <= 1'b1;
      @(posedge sys_clk);
      slave_data_strobe <= 1'b0;
      phase(1'b0);
      phase(1'b1);
      chk(8'(n), 8'h1E);
      // Self-test source, saturation and clearing.
      @(posedge sys_clk);
      self_test_pin <= 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
      chk({7'h00, self_test_active_q}, 8'h01);
      chk({7'h00, osc_enable_q}, 8'h01);
      host_u.wr(8'h24, 8'h00);
      repeat (5) @(posedge sys_clk);
      #1;
      chk({7'h00, self_test_active_q}, 8'h00);
      host_u.wr(8'h24, 8'h01);
      fwd_error <= 1'b1;
      repeat (300) @(posedge sys_clk);
      fwd_error <= 1'b0;
      host_u.wr(8'h24, 8'h00);
      host_u.rd(8'h25, got);
      chk(got, 8'hFF);
      host_u.wr(8'h24, 8'h01);
      repeat (3) @(posedge sys_clk);
      fwd_error <= 1'b1;
      repeat (2) @(posedge sys_clk);
      fwd_error <= 1'b0;
      host_u.wr(8'h24, 8'h00);
      host_u.rd(8'h25, got);
      chk(got, 8'h02);
      @(posedge sys_clk);
      power_down_n_input <= 1'b0;
      repeat (5) @(posedge sys_clk);
      power_down_n_input <= 1'b1;
      host_u.rd(8'h25, got);
      chk(got, 8'h00);
      // Forward loading, open and then blocked.
      host_u.wr(8'h28, 8'h00);
      fwd_load <= 1'b1;
      fwd_data <= 8'hFF;
      @(posedge sys_clk);
      fwd_load <= 1'b0;
      host_u.rd(8'h28, got);
      chk(got, 8'h0D);
      host_u.wr(8'h28, 8'h80);
      fwd_load <= 1'b1;
      @(posedge sys_clk);
      fwd_load <= 1'b0;
      host_u.rd(8'h28, got);
      chk(got, 8'h80);
      // Audio modes.
      host_u.wr(8'h28, 8'h89);
      repeat (2) @(posedge sys_clk);
      #1;
      chk({5'h00, aux_audio_active_q, surround_active_q, audio_oe_q}, 8'h07);
      data_island_mode <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk({7'h00, surround_active_q}, 8'h00);
      data_island_mode <= 1'b1;
      repeater_pin <= 1'b1;
      inband_valid <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      chk({7'h00, surround_active_q}, 8'h00);
      host_u.wr(8'h28, 8'h8D);
      repeat (2) @(posedge sys_clk);
      #1;
      chk({6'h00, surround_active_q, audio_oe_q}, 8'h00);
      low_frequency_select <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      chk({6'h00, osc_low_rate_q, low_freq_status_q}, 8'h03);
      complete_run();
   end
endmodule : tb_deser_selftest_i2c_audio_regs
bind dsr_regs dsr_chk chk_u (.*);
`default_nettype wire
